// ---- rtl/itc_pkg.sv ----
// Package for the isochronous transmit context control block.
// Assumes a 32-bit classic Wishbone slave port and eight contexts.
package itc_pkg;
    // Per-context register stride and set/clear word offsets; shared interrupt status/mask addresses.
    localparam logic [7:0] CTX_STRIDE    = 8'h10;
    localparam logic [7:0] OFS_SET       = 8'h00;
    localparam logic [7:0] OFS_CLR       = 8'h04;
    localparam logic [7:0] OFS_INT_STAT  = 8'h80;
    localparam logic [7:0] OFS_INT_MASK  = 8'h84;
    // Field positions of the context control word.
    localparam int BIT_SOC_EN  = 31;
    localparam int TGT_HI      = 30;
    localparam int TGT_LO      = 16;
    localparam int BIT_RUN     = 15;
    localparam int BIT_WAKE    = 12;
    localparam int BIT_DEAD    = 11;
    localparam int BIT_ACTIVE  = 10;
    localparam int CODE_HI     = 4;
    localparam int CODE_LO     = 0;
    // Mask of bits software may set or clear.
    localparam logic [31:0] SW_MASK = 32'hFFFF_9000;
    // Reset values.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Completion codes.
    localparam logic [4:0] EVT_TIMEOUT = 5'h0A;
    // Overflow cycle skips tolerated before the context is dead.
    localparam logic [2:0] MAX_SKIPS = 3'h7;
    // Interrupt status bit for the fatal error event.
    localparam int BIT_FATAL_IRQ = 24;
    // Number of contexts.
    localparam int N_CTX = 8;
endpackage

// ---- rtl/itc_ctx.sv ----
// One isochronous transmit context control register and its state.
// Assumes engine strobes are one-cycle pulses synchronous to clk_i.
`timescale 1ns/1ns
module itc_ctx
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        soft_rst_i,
    input  wire logic        set_we_i,
    input  wire logic        clr_we_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [14:0] cycle_now_i,
    input  wire logic        cycle_start_i,
    input  wire logic        fetch_i,
    input  wire logic        busy_i,
    input  wire logic        fatal_i,
    input  wire logic        last_done_i,
    input  wire logic [4:0]  last_code_i,
    input  wire logic        overflow_i,
    output logic [31:0]      ctrl_o,
    output logic             go_o,
    output logic             dead_evt_o
);
    logic        soc_q;
    logic [14:0] tgt_q;
    logic        run_q;
    logic        wake_q;
    logic        dead_q;
    logic        act_q;
    logic [4:0]  code_q;
    logic [2:0]  skip_q;
    logic        go_q;
    logic        any_rst;
    logic        match;
    logic        kill;

    assign any_rst = rst_i | soft_rst_i;
    // Match the timer value present in the same clock as the cycle start pulse.
    assign match   = cycle_start_i && (cycle_now_i == tgt_q);
    // Too many overflow skips is treated as fatal.
    assign kill    = fatal_i | (overflow_i && run_q && skip_q == itc_pkg::MAX_SKIPS);

    // run only by software or reset.
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
            run_q <= 1'b0;
        else if (set_we_i && wdata_i[itc_pkg::BIT_RUN])
            run_q <= 1'b1;
        else if (clr_we_i && wdata_i[itc_pkg::BIT_RUN])
            run_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (any_rst)
            tgt_q <= 15'h0000;
        else if (set_we_i)
            tgt_q <= tgt_q | wdata_i[itc_pkg::TGT_HI:itc_pkg::TGT_LO];
        else if (clr_we_i)
            tgt_q <= tgt_q & ~wdata_i[itc_pkg::TGT_HI:itc_pkg::TGT_LO];
    end

    // auto clear enable; hardware clear wins once active.
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
            soc_q <= 1'b0;
        else if (act_q)
            soc_q <= 1'b0;
        else if (set_we_i && wdata_i[itc_pkg::BIT_SOC_EN])
            soc_q <= 1'b1;
        else if (clr_we_i && wdata_i[itc_pkg::BIT_SOC_EN])
            soc_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (any_rst || !run_q)
            go_q <= 1'b0;
        else if (!soc_q || match)
            go_q <= 1'b1;
    end

    // wake cleared on fetch; a set in the same cycle wins.
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
            wake_q <= 1'b0;
        else if (set_we_i && wdata_i[itc_pkg::BIT_WAKE])
            wake_q <= 1'b1;
        else if (fetch_i || (clr_we_i && wdata_i[itc_pkg::BIT_WAKE]))
            wake_q <= 1'b0;
    end

    // dead on fatal error, cleared when run drops.
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
            dead_q <= 1'b0;
        else if (kill && run_q)
            dead_q <= 1'b1;
        else if (!run_q)
            dead_q <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (any_rst)
            act_q <= 1'b0;
        else
            act_q <= busy_i && go_q && run_q && !dead_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (any_rst)
            code_q <= 5'h00;
        else if (kill && run_q && !fatal_i)
            code_q <= itc_pkg::EVT_TIMEOUT;
        else if (last_done_i)
            code_q <= last_code_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (any_rst || !run_q)
            skip_q <= 3'h0;
        else if (overflow_i && skip_q != itc_pkg::MAX_SKIPS)
            skip_q <= skip_q + 3'h1;
    end

    // Fatal event pulse toward the interrupt status.
    always_ff @(posedge clk_i)
    begin
        if (any_rst)
            dead_evt_o <= 1'b0;
        else
            dead_evt_o <= kill && run_q && !dead_q;
    end

    assign ctrl_o = {soc_q, tgt_q, run_q, 2'b00, wake_q, dead_q, act_q, 5'b00000, code_q};
    assign go_o   = go_q && run_q && !dead_q;
endmodule

// ---- rtl/itc_top.sv ----
// Isochronous transmit context control bank with a Wishbone slave.
// Assumes the descriptor engine and cycle timer share clk_i.
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// How it works
// - With start-on-cycle enabled, a context transmits first in the target cycle.
// - The 15-bit target holds two seconds bits over the 13-bit cycle count.
// - The match uses the timer at the latest cycle start; work may begin early.
// - The start-on-cycle enable clears itself once the context is active.
// - Hardware changes run only on hardware or software reset.
// - Bits 14 to 13 and 9 to 5 read as zero.
// - Each descriptor fetch clears wake, except in a cycle where software also sets it.
// - A fatal error sets dead.
// - Dead clears when software clears run.
// - Active stays set while descriptors are processed.
// - After a last output command the completion code is written.
// - Up to seven overflow cycle skips are tolerated per running context.
// - Exceeding them sets dead, code timeout and the fatal event bit 24.
// - Eight independent contexts each own a control register.
module itc_top
#(
    parameter int N = itc_pkg::N_CTX
)
(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          soft_rst_i,
    input  wire logic          cyc_i,
    input  wire logic          stb_i,
    input  wire logic          we_i,
    input  wire logic [7:0]    adr_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic [31:0]   dat_i,
    input  wire logic [14:0]   cycle_now_i,
    input  wire logic          cycle_start_i,
    input  wire logic [N-1:0]  fetch_i,
    input  wire logic [N-1:0]  busy_i,
    input  wire logic [N-1:0]  fatal_i,
    input  wire logic [N-1:0]  last_done_i,
    input  wire logic [4:0]    last_code_i,
    input  wire logic [N-1:0]  overflow_i,
    output logic [31:0]        dat_o,
    output logic               ack_o,
    output logic [N-1:0]       go_o,
    output logic               irq_o
);
    logic [31:0]  ctrl [N];
    logic [N-1:0] go_w;
    logic [N-1:0] evt_w;
    logic         req;
    logic [31:0]  wmask;
    logic [31:0]  stat_q;
    logic [31:0]  mask_q;
    logic [N-1:0] go_q;
    logic         irq_q;

    assign req   = cyc_i && stb_i && !ack_o;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    ////////////////////////////////////////////////////////////////////////////
    // one instance per context.
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : ctx
            logic hit_set;
            logic hit_clr;
            assign hit_set = req && we_i && adr_i == 8'(g) * itc_pkg::CTX_STRIDE + itc_pkg::OFS_SET;
            assign hit_clr = req && we_i && adr_i == 8'(g) * itc_pkg::CTX_STRIDE + itc_pkg::OFS_CLR;
            itc_ctx u_ctx
            (
                .clk_i         (clk_i),
                .rst_i         (rst_i),
                .soft_rst_i    (soft_rst_i),
                .set_we_i      (hit_set),
                .clr_we_i      (hit_clr),
                .wdata_i       (dat_i & wmask & itc_pkg::SW_MASK),
                .cycle_now_i   (cycle_now_i),
                .cycle_start_i (cycle_start_i),
                .fetch_i       (fetch_i[g]),
                .busy_i        (busy_i[g]),
                .fatal_i       (fatal_i[g]),
                .last_done_i   (last_done_i[g]),
                .last_code_i   (last_code_i),
                .overflow_i    (overflow_i[g]),
                .ctrl_o        (ctrl[g]),
                .go_o          (go_w[g]),
                .dead_evt_o    (evt_w[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Bus acknowledge, one cycle after the request.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= req;
    end

    // Read mux; unmapped addresses read zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (req)
        begin
            dat_o <= 32'h0000_0000;
            if (adr_i == itc_pkg::OFS_INT_STAT)
                dat_o <= stat_q;
            else if (adr_i == itc_pkg::OFS_INT_MASK)
                dat_o <= mask_q;
            else if (adr_i < 8'(N) * itc_pkg::CTX_STRIDE && adr_i[3] == 1'b0)
                dat_o <= ctrl[adr_i[6:4]];
        end
    end

    // sticky fatal event, write one to clear, set wins.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stat_q <= itc_pkg::CTRL_RESET;
        else
        begin
            if (req && we_i && adr_i == itc_pkg::OFS_INT_STAT)
                stat_q <= stat_q & ~(dat_i & wmask);
            if (|evt_w)
                stat_q[itc_pkg::BIT_FATAL_IRQ] <= 1'b1;
        end
    end

    // Interrupt mask register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mask_q <= itc_pkg::CTRL_RESET;
        else if (req && we_i && adr_i == itc_pkg::OFS_INT_MASK)
            mask_q <= (mask_q & ~wmask) | (dat_i & wmask);
    end

    // Registered outputs.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_q <= 1'b0;
            go_q  <= '0;
        end
        else
        begin
            irq_q <= |(stat_q & mask_q);
            go_q  <= go_w;
        end
    end

    assign irq_o = irq_q;
    assign go_o  = go_q;
endmodule

// ---- testbench/itc_top_assertions.sv ----
// Protocol and behaviour checks for the transmit context control bank.
// Assumes it is bound to the top module and sees its ports by name.
`timescale 1ns/1ns
module itc_top_assertions
#(
    parameter int N = 8
)
(
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         soft_rst_i,
    input wire logic         cyc_i,
    input wire logic         stb_i,
    input wire logic         cycle_start_i,
    input wire logic [N-1:0] fatal_i,
    input wire logic [N-1:0] overflow_i,
    input wire logic         ack_o,
    input wire logic [31:0]  dat_o,
    input wire logic [N-1:0] go_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [3:0] ovf_q;

    // Counts overflow pulses while context 0 is released to transmit.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !go_o[0])
            ovf_q <= 4'h0;
        else if (overflow_i[0])
            ovf_q <= ovf_q + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack;
        ack_o ##1 !ack_o;
    endsequence
    property p_ack_after_req;
        s_req |=> s_ack;
    endproperty
    property p_ack_cause;
        ack_o |-> $past(cyc_i && stb_i);
    endproperty
    property p_rsvd_zero;
        ack_o |-> dat_o[14:13] == 2'h0 && dat_o[9:5] == 5'h00;
    endproperty
    property p_dat_hold;
        !ack_o |-> $stable(dat_o);
    endproperty
    property p_fatal_stop;
        fatal_i[N-1] |-> ##3 !go_o[N-1];
    endproperty
    property p_soft_clear;
        soft_rst_i |-> ##2 go_o == '0;
    endproperty
    property p_go_cause;
        $rose(go_o[0]) |-> $past(ack_o) || $past(ack_o, 2) || $past(ack_o, 3)
            || $past(cycle_start_i, 2) || $past(cycle_start_i, 3);
    endproperty
    property p_ovf_kill;
        overflow_i[0] && ovf_q == 4'h7 |-> ##3 !go_o[0];
    endproperty

    a_ack_after_req: assert property (p_ack_after_req)
        else $error("ack not a single pulse after request");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bits read nonzero");
    a_dat_hold: assert property (p_dat_hold)
        else $error("read data moved without ack");
    a_fatal_stop: assert property (p_fatal_stop)
        else $error("context still released after fatal error");
    a_soft_clear: assert property (p_soft_clear)
        else $error("soft reset left a context released");
    a_go_cause: assert property (p_go_cause)
        else $error("release without write or cycle start");
    a_ovf_kill: assert property (p_ovf_kill)
        else $error("eighth overflow did not stop context");
endmodule

// ---- testbench/itc_top_test.sv ----
// Directed bench for the transmit context control bank.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/1ns
module itc_top_test;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        soft_rst_i = 1'b0;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [14:0] cycle_now_i = 15'h0000;
    logic        cycle_start_i = 1'b0;
    logic [7:0]  fetch_i = 8'h00;
    logic [7:0]  busy_i = 8'h00;
    logic [7:0]  fatal_i = 8'h00;
    logic [7:0]  last_done_i = 8'h00;
    logic [4:0]  last_code_i = 5'h00;
    logic [7:0]  overflow_i = 8'h00;
    logic [31:0] dat_o;
    logic [31:0] d;
    logic        ack_o;
    logic        irq_o;
    logic [7:0]  go_o;
    int          n_fail = 0;
    int          compares = 0;

    itc_top u_dut
    (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .soft_rst_i    (soft_rst_i),
        .cyc_i         (cyc_i),
        .stb_i         (stb_i),
        .we_i          (we_i),
        .adr_i         (adr_i),
        .sel_i         (sel_i),
        .dat_i         (dat_i),
        .cycle_now_i   (cycle_now_i),
        .cycle_start_i (cycle_start_i),
        .fetch_i       (fetch_i),
        .busy_i        (busy_i),
        .fatal_i       (fatal_i),
        .last_done_i   (last_done_i),
        .last_code_i   (last_code_i),
        .overflow_i    (overflow_i),
        .dat_o         (dat_o),
        .ack_o         (ack_o),
        .go_o          (go_o),
        .irq_o         (irq_o)
    );

    // Free running 100 MHz clock.
    initial forever #5 clk_i = ~clk_i;

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic Wishbone cycle; read data lands in d.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= v;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        d = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Pulses the cycle start with a given timer value.
    task automatic cstart(input logic [14:0] v);
        cycle_now_i <= v;
        @(posedge clk_i) cycle_start_i <= 1'b1;
        @(posedge clk_i) cycle_start_i <= 1'b0;
        tick(3);
    endtask

    task automatic ovf(input int n);
        repeat (n)
        begin
            @(posedge clk_i) overflow_i <= 8'h01;
            @(posedge clk_i) overflow_i <= 8'h00;
        end
        tick(3);
    endtask

    task automatic wrap_up;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Cuts a hang short.
    initial
    begin
        #100000;
        n_fail++;
        wrap_up;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial
    begin
        tick(4);
        rst_i <= 1'b0;
        rd(8'h00);
        chk(d, 32'h0000_0000);
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00);
        chk(d, 32'hFFFF_9000);
        chk(32'(go_o), 32'h0000_0000);
        @(posedge clk_i) fetch_i <= 8'h01;
        @(posedge clk_i) fetch_i <= 8'h00;
        rd(8'h00);
        chk(d, 32'hFFFF_8000);
        $display("test 1 done");
        cstart(15'h7FFE);
        chk(32'(go_o), 32'h0000_0000);
        cstart(15'h7FFF);
        chk(32'(go_o), 32'h0000_0001);
        busy_i <= 8'h01;
        tick(3);
        rd(8'h00);
        chk(d, 32'h7FFF_8400);
        last_code_i <= 5'h11;
        @(posedge clk_i) last_done_i <= 8'h01;
        @(posedge clk_i) last_done_i <= 8'h00;
        rd(8'h00);
        chk(d, 32'h7FFF_8411);
        $display("test 2 done");
        ovf(7);
        chk(32'(go_o), 32'h0000_0001);
        ovf(1);
        chk(32'(go_o), 32'h0000_0000);
        rd(8'h00);
        chk(d, 32'h7FFF_880A);
        rd(8'h80);
        chk(d & 32'h0100_0000, 32'h0100_0000);
        chk(32'(irq_o), 32'h0000_0000);
        wr(8'h84, 32'h0100_0000);
        tick(2);
        chk(32'(irq_o), 32'h0000_0001);
        wr(8'h80, 32'h0100_0000);
        tick(2);
        chk(32'(irq_o), 32'h0000_0000);
        $display("test 3 done");
        wr(8'h04, 32'h0000_8000);
        busy_i <= 8'h00;
        rd(8'h00);
        chk(d, 32'h7FFF_000A);
        rd(8'h04);
        chk(d, 32'h7FFF_000A);
        wr(8'h70, 32'h0000_8000);
        tick(3);
        chk(32'(go_o), 32'h0000_0080);
        @(posedge clk_i) fatal_i <= 8'h80;
        @(posedge clk_i) fatal_i <= 8'h00;
        tick(3);
        chk(32'(go_o), 32'h0000_0000);
        chk(32'(irq_o), 32'h0000_0001);
        rd(8'h70);
        chk(d, 32'h0000_8800);
        @(posedge clk_i) soft_rst_i <= 1'b1;
        @(posedge clk_i) soft_rst_i <= 1'b0;
        rd(8'h70);
        chk(d, 32'h0000_0000);
        // Byte enables that leave out the run byte must not set run.
        sel_i <= 4'hC;
        wr(8'h70, 32'h0000_8000);
        sel_i <= 4'hF;
        rd(8'h70);
        chk(d, 32'h0000_0000);
        rd(8'hC0);
        chk(d, 32'h0000_0000);
        $display("test 4 done");
        wrap_up;
    end
endmodule

bind itc_top itc_top_assertions #(.N(N)) u_chk
(
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .soft_rst_i    (soft_rst_i),
    .cyc_i         (cyc_i),
    .stb_i         (stb_i),
    .cycle_start_i (cycle_start_i),
    .fatal_i       (fatal_i),
    .overflow_i    (overflow_i),
    .ack_o         (ack_o),
    .dat_o         (dat_o),
    .go_o          (go_o)
);
